// ### sim/cfg_source.sv
// Far side: a host clocking an image in, or a serial memory answering
// the read. Assumes select arrives already resolved with its pull-up.
`timescale 1ns/1ps
`default_nettype none

module cfg_source #(
    parameter int IB = 16
) (
    // Mode and image
    input wire logic clk,
    input wire logic active,
    input wire logic [IB-1:0] image,
    // Device pads
    input wire logic clk_out,
    input wire logic sel_n,
    input wire logic cmd,
    // Lines toward the device
    output logic clk_line,
    output logic data,
    output logic [31:0] cmd_seen
);
    int rises = 0;
    logic clk_q = 1'b0;
    // Clock held low, data pulled high outside frames
    logic host_clk = 1'b0;
    logic host_data = 1'b1;
    logic mem_data = 1'b1;

    // Host clock in both modes; host data in passive mode, memory data in active mode
    assign clk_line = host_clk;
    assign data = active ? mem_data : host_data;

    // Host frame: clock runs only here, data moves on the falling edge;
    // starts off the system clock edge to keep clear of its sampling
    task automatic send(input int n, input logic [IB-1:0] img);
        #1;
        for (int i = 0; i < n; i++) begin
            host_data = img[i % IB];
            #32 host_clk = 1'b1;
            #32 host_clk = 1'b0;
        end
        host_data = 1'b1;
    endtask

    // Memory: command taken on rises, data moved after falls
    always @(posedge clk) begin
        clk_q <= clk_out;
        if (!active || sel_n) begin
            rises <= 0;
            mem_data <= 1'b1;
        end else if (clk_out && !clk_q) begin
            rises <= rises + 1;
            if (rises < 32) cmd_seen <= {cmd_seen[30:0], cmd};
        end else if (!clk_out && clk_q && rises >= 32) begin
            mem_data <= image[(rises - 32) % IB];
        end
    end
endmodule

`default_nettype wire

// ### sim/load_port_asserts.sv
// Checker for the serial configuration load port pad behaviour.
// Assumes it is bound to the port's top module and sees only its pins.
`timescale 1ns/1ps
`default_nettype none

module load_port_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chain_done_enable,
    // Pads
    input wire logic config_clock_out,
    input wire logic config_clock_oe,
    input wire logic serial_cmd_oe,
    input wire logic memory_select_out_n,
    input wire logic memory_select_oe,
    input wire logic chain_done_out_n,
    input wire logic chain_done_oe,
    input wire logic load_complete_status_oe,
    // Stream
    input wire logic config_bit_valid,
    input wire logic load_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Pad roles across the load
    a_chain_low: assert property (load_done && chain_done_enable |->
        chain_done_oe && !chain_done_out_n) else $error("chain not low");
    a_chain_high: assert property (chain_done_oe && !load_done |->
        chain_done_out_n) else $error("chain low early");
    a_optional_hiz: assert property (!load_done && !chain_done_enable |->
        !chain_done_oe) else $error("optional pin driven");
    a_cmd_driven: assert property (config_clock_oe |-> serial_cmd_oe)
        else $error("command pad idle");
    a_select_low: assert property (config_clock_oe |-> memory_select_oe
        && !memory_select_out_n) else $error("select not low");
    // Generated clock keeps its half period of eight cycles
    a_clock_half: assert property ($rose(config_clock_out) ##1
        config_clock_oe |-> config_clock_out[*7] ##1 !config_clock_out)
        else $error("clock half period");
    a_clock_release: assert property (load_done |-> !config_clock_oe)
        else $error("clock still driven");
    a_status_release: assert property ($fell(load_complete_status_oe)
        |-> load_done) else $error("status released early");
    a_last_bit: assert property ($rose(load_done) |-> config_bit_valid)
        else $error("done without last bit");
    a_ignore_after: assert property (load_done && $past(load_done)
        |-> !config_bit_valid) else $error("bit after done");

    // Main scenarios reached
    c_active: cover property ($rose(load_done) && memory_select_oe);
    c_passive: cover property ($rose(load_done) && !memory_select_oe);
    c_clock: cover property ($fell(config_clock_out));
endmodule

bind serial_config_load_port load_port_asserts u_chk (.clk, .sys_rst,
    .chain_done_enable, .config_clock_out, .config_clock_oe, .serial_cmd_oe,
    .memory_select_out_n, .memory_select_oe, .chain_done_out_n,
    .chain_done_oe, .load_complete_status_oe, .config_bit_valid, .load_done);

`default_nettype wire

// ### sim/testbench.sv
// Bench for the load port: random images in both modes, an abort, and
// clock activity after loading. Assumes a short image for run time.
`timescale 1ns/1ps
`default_nettype none
`include "config_load_defines.svh"

module testbench;
    localparam int IB = 16;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic act = 1'b0;
    logic ce_n = 1'b1;
    logic cde = 1'b0;
    logic [IB-1:0] image = '0;
    logic [IB-1:0] got = '0;
    cfg_load_pkg::user_io_t user_io = '0;
    cfg_load_pkg::pin_bundle_t pins;
    logic clk_out, clk_oe, cmd_out, cmd_oe, sel_n, sel_oe, chain_n, chain_oe;
    logic st_out, st_oe, cbit, cvalid, done, src_clk, src_data;
    logic [31:0] cmd_seen;
    int failures = 0;
    int checks = 0;
    int nbits = 0;
    int seed = 32'h597769FE;

    // Clock pin follows the device while it drives, else the far side
    assign pins = {act, ce_n, clk_oe ? clk_out : src_clk, src_data};

    initial forever #2.5 clk = ~clk;

    serial_config_load_port #(.IMAGE_BITS(IB)) u_dut (.clk(clk),
        .sys_rst(sys_rst), .clk_en(1'b1), .pins_in(pins),
        .chain_done_enable(cde), .user_io(user_io),
        .config_clock_out(clk_out), .config_clock_oe(clk_oe),
        .serial_cmd_out(cmd_out), .serial_cmd_oe(cmd_oe),
        .memory_select_out_n(sel_n), .memory_select_oe(sel_oe),
        .chain_done_out_n(chain_n), .chain_done_oe(chain_oe),
        .load_complete_status_out(st_out), .load_complete_status_oe(st_oe),
        .config_bit(cbit), .config_bit_valid(cvalid), .load_done(done));

    cfg_source #(.IB(IB)) u_src (.clk(clk), .active(act), .image(image),
        .clk_out(clk_out), .sel_n(sel_oe ? sel_n : 1'b1), .cmd(cmd_out),
        .clk_line(src_clk), .data(src_data), .cmd_seen(cmd_seen));

    // Gather the stream; the first bit ends at the bottom
    always @(posedge clk) begin
        if (sys_rst || ce_n) begin
            nbits <= 0;
        end else if (cvalid === 1'b1) begin
            got <= {cbit, got[IB-1:1]};
            nbits <= nbits + 1;
        end
    end

    task automatic check(input string n, input logic [31:0] e,
        input logic [31:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Reset with the enable high so no load starts early, then enable
    task automatic start(input logic m, input logic en, input logic [15:0] i);
        sys_rst <= 1'b1;
        ce_n <= 1'b1;
        act <= m;
        cde <= en;
        image <= i;
        user_io <= cfg_load_pkg::user_io_t'(6'($random(seed)));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        ce_n <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    // Bounded wait for the end, then pads and stream against the image
    task automatic finish_load(input int k);
        int n = 0;
        if (!act) u_src.send(IB, image);
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        check("done", 1, done);
        check("image", image, got);
        check("status oe", 0, st_oe);
        check("status out", 0, st_out);
        check("clock oe", 0, clk_oe);
        check("chain", cde ? 2'b01 : {user_io.chain_out, user_io.chain_oe},
            {chain_n, chain_oe});
        if (act) begin
            check("command", {`CFG_READ_CMD, `CFG_START_ADDR}, cmd_seen);
            check("select", 2'b11, {sel_n, sel_oe});
        end else begin
            check("cmd pin", {user_io.cmd_out, user_io.cmd_oe},
                {cmd_out, cmd_oe});
            check("sel pin", {user_io.select_out, user_io.select_oe},
                {sel_n, sel_oe});
        end
        u_src.send(4, ~image);
        @(posedge clk);
        check("bit count", IB, nbits);
        $display("test %0d finished", k);
    endtask

    initial begin
        start(1'b1, 1'b1, 16'h8001);
        finish_load(0);
        for (int k = 1; k < 5; k++) begin
            start(k[0], k[1], 16'($random(seed)));
            finish_load(k);
        end
        // Abort in mid-load, then a full load from the first bit
        start(1'b0, 1'b0, 16'($random(seed)));
        u_src.send(5, ~image);
        @(posedge clk);
        ce_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("abort done", 0, done);
        check("abort status", 1, st_oe);
        ce_n <= 1'b0;
        repeat (10) @(posedge clk);
        finish_load(5);
        finish_test();
    end

    // Watchdog well past six loads
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule

`default_nettype wire

// ### verilog/cfg_load_pkg.sv
// Types shared by the serial configuration load port.
// Assumes the constants header is included where counts are needed.
package cfg_load_pkg;

    // Load sequence, Gray coded along idle, load, done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_DONE = 2'b11
    } load_state_t;

    // Pins sampled from outside the clock domain
    typedef struct packed {
        logic active_serial_mode;
        logic chip_enable_in_n;
        logic config_clock;
        logic config_serial_in;
    } pin_bundle_t;

    // User logic drive for the optional pins once they turn into user I/O
    typedef struct packed {
        logic chain_out;
        logic chain_oe;
        logic cmd_out;
        logic cmd_oe;
        logic select_out;
        logic select_oe;
    } user_io_t;

endpackage

// ### verilog/config_load_defines.svh
// Constants for the serial configuration load port: counts, commands
// and reset values. Assumes inclusion by bare name, definitions only.
`ifndef CONFIG_LOAD_DEFINES_SVH
`define CONFIG_LOAD_DEFINES_SVH

// Configuration image length in bits
`define CFG_IMAGE_BITS 1024
// Width of the bit counter
`define CFG_CNT_W 20
// Generated clock half period, in system clock cycles; long enough for
// returned data to clear the three-stage pin filter before the next rise
`define CFG_AS_HALF_CYC 8
// Read command and start address sent ahead of the image
`define CFG_READ_CMD 8'h03
`define CFG_START_ADDR 24'h000000
// Command plus address length in bits
`define CFG_CMD_BITS 32
// Reset level of the active-low pins while not driven as asserted
`define CFG_INACTIVE_N 1'b1

`endif

// ### verilog/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rise detect.
// Assumes inputs are asynchronous to clk; clk_en freezes all stages.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Raw pins
    input wire logic [W-1:0] pin_in,
    // Filtered level and one-cycle rise pulse
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, rise_reg;
    logic [W-1:0] lvl_next, rise_next;

    // A change counts once stages two and three agree
    always_comb begin
        lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
        rise_next = lvl_next & ~lvl_reg;
    end

    // Stage one feeds only stage two; reset to each pin's idle level
    // so no false start or edge follows reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            lvl_reg <= RST_VAL;
            rise_reg <= '0;
        end else if (clk_en) begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
            rise_reg <= rise_next;
        end
    end

    assign level = lvl_reg;
    assign rise = rise_reg;
endmodule

`default_nettype wire

// ### verilog/serial_config_load_port.sv
// Serial configuration load port: passive mode with an external clock,
// active mode driving clock, select and command toward a serial memory.
// Assumes pins arrive asynchronously and pad logic resolves the enables.
`timescale 1ns/1ps
`default_nettype none
`include "config_load_defines.svh"

module serial_config_load_port #(
    parameter int IMAGE_BITS = `CFG_IMAGE_BITS,
    parameter int CNT_W = `CFG_CNT_W,
    parameter int AS_HALF_CYC = `CFG_AS_HALF_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Raw configuration pins
    input wire cfg_load_pkg::pin_bundle_t pins_in,
    // Option: chain done pin keeps its role rather than user I/O
    input wire logic chain_done_enable,
    // User drive for optional pins once free
    input wire cfg_load_pkg::user_io_t user_io,
    // Configuration clock pad
    output logic config_clock_out,
    output logic config_clock_oe,
    // Serial command pad toward memory
    output logic serial_cmd_out,
    output logic serial_cmd_oe,
    // Memory select pad
    output logic memory_select_out_n,
    output logic memory_select_oe,
    // Chain done pad
    output logic chain_done_out_n,
    output logic chain_done_oe,
    // Open-drain load complete status pad
    output logic load_complete_status_out,
    output logic load_complete_status_oe,
    // Received image bit stream
    output logic config_bit,
    output logic config_bit_valid,
    output logic load_done
);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(IMAGE_BITS - 1);
    localparam logic [CNT_W-1:0] LAST_CMD = CNT_W'(`CFG_CMD_BITS - 1);
    localparam logic [7:0] LAST_HALF = 8'(AS_HALF_CYC - 1);
    localparam logic [`CFG_CMD_BITS-1:0] READ_WORD =
        {`CFG_READ_CMD, `CFG_START_ADDR};

    cfg_load_pkg::pin_bundle_t lvl, rise;
    cfg_load_pkg::load_state_t state_reg, state_next;
    logic as_mode_reg, as_mode_next;
    logic in_cmd_reg, in_cmd_next;
    logic [CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] half_reg, half_next;
    logic [`CFG_CMD_BITS-1:0] cmd_sr_reg, cmd_sr_next;
    logic clk_o_reg, clk_o_next, clk_oe_reg, clk_oe_next;
    logic cmd_o_reg, cmd_o_next, cmd_oe_reg, cmd_oe_next;
    logic sel_o_reg, sel_o_next, sel_oe_reg, sel_oe_next;
    logic chain_o_reg, chain_o_next, chain_oe_reg, chain_oe_next;
    logic stat_oe_reg, stat_oe_next;
    logic bit_reg, bit_next, valid_reg, valid_next;
    logic done_reg, done_next;
    logic take_bit;

    // All four pins pass the same three-stage filter; chip enable and
    // data reset high, their idle levels
    pin_sync #(
        .W(4),
        .RST_VAL(4'h5)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(pins_in),
        .level(lvl),
        .rise(rise)
    );

    // Sequencer, clock generator and pad control
    always_comb begin
        state_next = state_reg;
        as_mode_next = as_mode_reg;
        in_cmd_next = in_cmd_reg;
        bit_cnt_next = bit_cnt_reg;
        half_next = half_reg;
        cmd_sr_next = cmd_sr_reg;
        clk_o_next = clk_o_reg;
        clk_oe_next = clk_oe_reg;
        cmd_o_next = cmd_o_reg;
        cmd_oe_next = cmd_oe_reg;
        sel_o_next = sel_o_reg;
        sel_oe_next = sel_oe_reg;
        chain_o_next = chain_o_reg;
        chain_oe_next = chain_oe_reg;
        stat_oe_next = stat_oe_reg;
        bit_next = bit_reg;
        valid_next = 1'b0;
        done_next = done_reg;
        take_bit = 1'b0;
        case (state_reg)
            cfg_load_pkg::ST_IDLE: begin
                stat_oe_next = 1'b1;
                chain_o_next = `CFG_INACTIVE_N;
                chain_oe_next = chain_done_enable;
                clk_oe_next = 1'b0;
                cmd_oe_next = 1'b0;
                sel_oe_next = 1'b0;
                // Start only while chip enable is low
                if (!lvl.chip_enable_in_n) begin
                    state_next = cfg_load_pkg::ST_LOAD;
                    as_mode_next = lvl.active_serial_mode;
                    bit_cnt_next = '0;
                    half_next = '0;
                    in_cmd_next = lvl.active_serial_mode;
                    cmd_sr_next = READ_WORD << 1;
                    clk_o_next = 1'b0;
                    clk_oe_next = lvl.active_serial_mode;
                    cmd_o_next = READ_WORD[`CFG_CMD_BITS-1];
                    cmd_oe_next = lvl.active_serial_mode;
                    sel_o_next = 1'b0;
                    sel_oe_next = lvl.active_serial_mode;
                end
            end
            cfg_load_pkg::ST_LOAD: begin
                if (lvl.chip_enable_in_n) begin
                    state_next = cfg_load_pkg::ST_IDLE;
                end else if (as_mode_reg) begin
                    // Generated clock, one toggle per half period
                    half_next = half_reg + 8'h01;
                    if (half_reg == LAST_HALF) begin
                        half_next = '0;
                        clk_o_next = ~clk_o_reg;
                        if (!clk_o_reg) begin
                            // Rising edge: command bit taken or data read
                            if (in_cmd_reg) begin
                                bit_cnt_next = bit_cnt_reg + 1'b1;
                                if (bit_cnt_reg == LAST_CMD) begin
                                    in_cmd_next = 1'b0;
                                    bit_cnt_next = '0;
                                end
                            end else begin
                                take_bit = 1'b1;
                            end
                        end else begin
                            // Falling edge: next command bit goes out
                            cmd_o_next = cmd_sr_reg[`CFG_CMD_BITS-1];
                            cmd_sr_next = cmd_sr_reg << 1;
                        end
                    end
                end else if (rise.config_clock) begin
                    take_bit = 1'b1;
                end
                // One image bit per sample on the single data input
                if (take_bit) begin
                    bit_next = lvl.config_serial_in;
                    valid_next = 1'b1;
                    bit_cnt_next = bit_cnt_reg + 1'b1;
                    if (bit_cnt_reg == LAST_BIT) begin
                        state_next = cfg_load_pkg::ST_DONE;
                        done_next = 1'b1;
                        stat_oe_next = 1'b0;
                        clk_oe_next = 1'b0;
                        sel_o_next = `CFG_INACTIVE_N;
                        chain_o_next = 1'b0;
                    end
                end
            end
            cfg_load_pkg::ST_DONE: begin
                // Clock and data pins no longer looked at
                clk_oe_next = 1'b0;
                stat_oe_next = 1'b0;
                if (chain_done_enable) begin
                    chain_o_next = 1'b0;
                    chain_oe_next = 1'b1;
                end else begin
                    chain_o_next = user_io.chain_out;
                    chain_oe_next = user_io.chain_oe;
                end
                // Active mode keeps memory deselected; passive frees pins
                if (!as_mode_reg) begin
                    cmd_o_next = user_io.cmd_out;
                    cmd_oe_next = user_io.cmd_oe;
                    sel_o_next = user_io.select_out;
                    sel_oe_next = user_io.select_oe;
                end
            end
            default: begin
                state_next = cfg_load_pkg::ST_IDLE;
            end
        endcase
    end

    // Register all state and pads; clk_en freezes everything
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= cfg_load_pkg::ST_IDLE;
            as_mode_reg <= 1'b0;
            in_cmd_reg <= 1'b0;
            bit_cnt_reg <= '0;
            half_reg <= '0;
            cmd_sr_reg <= '0;
            clk_o_reg <= 1'b0;
            clk_oe_reg <= 1'b0;
            cmd_o_reg <= 1'b0;
            cmd_oe_reg <= 1'b0;
            sel_o_reg <= `CFG_INACTIVE_N;
            sel_oe_reg <= 1'b0;
            chain_o_reg <= `CFG_INACTIVE_N;
            chain_oe_reg <= 1'b0;
            stat_oe_reg <= 1'b1;
            bit_reg <= 1'b0;
            valid_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            as_mode_reg <= as_mode_next;
            in_cmd_reg <= in_cmd_next;
            bit_cnt_reg <= bit_cnt_next;
            half_reg <= half_next;
            cmd_sr_reg <= cmd_sr_next;
            clk_o_reg <= clk_o_next;
            clk_oe_reg <= clk_oe_next;
            cmd_o_reg <= cmd_o_next;
            cmd_oe_reg <= cmd_oe_next;
            sel_o_reg <= sel_o_next;
            sel_oe_reg <= sel_oe_next;
            chain_o_reg <= chain_o_next;
            chain_oe_reg <= chain_oe_next;
            stat_oe_reg <= stat_oe_next;
            bit_reg <= bit_next;
            valid_reg <= valid_next;
            done_reg <= done_next;
        end
    end

    // Pads straight from flip-flops; status only ever pulls low
    assign config_clock_out = clk_o_reg;
    assign config_clock_oe = clk_oe_reg;
    assign serial_cmd_out = cmd_o_reg;
    assign serial_cmd_oe = cmd_oe_reg;
    assign memory_select_out_n = sel_o_reg;
    assign memory_select_oe = sel_oe_reg;
    assign chain_done_out_n = chain_o_reg;
    assign chain_done_oe = chain_oe_reg;
    assign load_complete_status_out = 1'b0;
    assign load_complete_status_oe = stat_oe_reg;
    assign config_bit = bit_reg;
    assign config_bit_valid = valid_reg;
    assign load_done = done_reg;
endmodule

`default_nettype wire
